/* File: hw/msc_consts.vh */
// Constants of the operating-mode and strap configuration controller
// Behaviour
// [RL1] Six modes; Normal is the main one
// [RL2] Init entered at power-up and soft reset
// [RL3] Stop keeps main regulator output enabled
// [RL4] Sleep switches main regulator output off
// [RL5] Restart after wake or failure, asserts reset
// [RL6] Critical failures such as overtemperature enter Fail-Safe
// [RL7] Development mode: watchdog fail signals interrupt, no reset
// [RL8] Development mode allows watchdog reset re-enable
// [RL9] Watchdog always starts with long open window
// [RL10] Configuration and diagnosis over 32-bit SPI
// [RL11] Weak pull-up on interrupt pin after reset release
// [RL12] Development strap evaluated only in qualified Init
// [RL13] Low filtered strap plus next command latches mode
// [RL14] Strap filter starts at 1 on reset release
// [RL15] Autonomous mode change cancels development mode; code clears it only on an autonomous change out of qualified Init
// [RL16] Pulled-down CRC strap enables CRC, open disables
// [RL17] CRC strap sampled in Init/Restart, reset low
// [RL18] CRC strap filtered, latched at reset release
// [RL19] Frame 67AAAA0E switches CRC on
// [RL20] Frame E7AAAAC3 switches CRC off
// [RL21] Host sends recovery frames only in Normal
// [RL22] Power-on starts Init, long window after release
// [RL23] Stop ignores writes and flags SPI failure, exceptions
// [RL24] Recovery frames matched on raw word before CRC
`ifndef MSC_CONSTS_VH
`define MSC_CONSTS_VH

`define MSC_MODE_INIT 3'h0
`define MSC_MODE_NORMAL 3'h1
`define MSC_MODE_STOP 3'h2
`define MSC_MODE_SLEEP 3'h3
`define MSC_MODE_RESTART 3'h4
`define MSC_MODE_FAILSAFE 3'h5

`define MSC_FRAME_CRC_ON 32'h67AAAA0E
`define MSC_FRAME_CRC_OFF 32'hE7AAAAC3

`define MSC_CLK_MHZ 50
`define MSC_RESET_DELAY_US 10
`define MSC_RESET_DELAY_CYC (`MSC_RESET_DELAY_US * `MSC_CLK_MHZ)
`define MSC_TEST_FILT_US 2
`define MSC_TEST_FILT_CYC (`MSC_TEST_FILT_US * `MSC_CLK_MHZ)
`define MSC_CFG_FILT_US 1
`define MSC_CFG_FILT_CYC (`MSC_CFG_FILT_US * `MSC_CLK_MHZ)

`define MSC_CRC_RST 1'h0
`define MSC_SDM_RST 1'h0

`endif

/* File: hw/msc_filter.v */
// Level filter: output follows the input only after a stable run
`timescale 1ns/1ns
module msc_filter #(
  parameter CYC = 100,
  parameter [0:0] INIT = 1'h1
) (
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire load,
  input wire run,
  input wire pin,
  output reg filt
);
  reg [15:0] cnt;

  always @(posedge clk) begin
    if (sys_rst) begin
      filt <= 1'h1;
      cnt <= 16'h0000;
    end else if (clk_en) begin
      if (load) begin
        filt <= INIT;
        cnt <= 16'h0000;
      end else if (!run || pin == filt) begin
        // Any bounce restarts the stable-time count
        cnt <= 16'h0000;
      end else if (cnt == CYC[15:0] - 16'h0001) begin
        filt <= pin;
        cnt <= 16'h0000;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule // msc_filter

/* File: hw/msc_top.v */
// Operating-mode controller with strap capture and CRC recovery frames
`timescale 1ns/1ns
`include "msc_consts.vh"
module msc_top #(
  parameter RESET_DELAY_CYC = `MSC_RESET_DELAY_CYC,
  parameter TEST_FILT_CYC = `MSC_TEST_FILT_CYC,
  parameter CFG_FILT_CYC = `MSC_CFG_FILT_CYC
) (
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire cmd_valid,
  input wire [31:0] cmd_frame,
  input wire cmd_is_write,
  input wire cmd_mode_set,
  input wire [2:0] cmd_mode_sel,
  input wire cmd_soft_reset,
  input wire cmd_wd_refresh,
  input wire cmd_status_access,
  input wire wd_rst_reenable,
  input wire wake_event,
  input wire wd_fail,
  input wire regulator_uv,
  input wire thermal_shutdown,
  input wire vcc_above_rtx,
  input wire por_flag,
  input wire int_test_pin_in,
  input wire pwm_crc_strap_pin,
  output reg [2:0] mode,
  output reg sdm_active,
  output reg reset_output_low,
  output reg int_test_pullup_en,
  output reg main_regulator_output,
  output reg wd_enable,
  output reg wd_start_long,
  output reg crc_enable,
  output reg spi_fail,
  output reg cmd_accept,
  output reg wd_fail_int
);
  reg [2:0] next_mode;
  reg por_init;
  reg [15:0] rd_cnt;
  wire test_filt;
  wire crc_filt;

  // Stop mode lets only a few write commands through
  wire exempt = (cmd_mode_set && cmd_mode_sel == `MSC_MODE_NORMAL) || cmd_soft_reset ||
    cmd_wd_refresh || cmd_status_access;
  wire stop_block = (mode == `MSC_MODE_STOP) && cmd_valid && cmd_is_write && !exempt; // RL23
  wire eff_cmd = cmd_valid && !stop_block;
  wire mode_cmd = eff_cmd && cmd_mode_set;
  wire soft_cmd = eff_cmd && cmd_soft_reset;

  // Raw word compare happens ahead of any CRC check
  wire frame_on = cmd_valid && cmd_frame == `MSC_FRAME_CRC_ON; // RL24
  wire frame_off = cmd_valid && cmd_frame == `MSC_FRAME_CRC_OFF; // RL24

  wire rd_done = !reset_output_low && (rd_cnt == RESET_DELAY_CYC[15:0] - 16'h0001);
  wire reset_phase = (mode == `MSC_MODE_RESTART) || (mode == `MSC_MODE_INIT && por_init);

  wire wd_rst_ok = !sdm_active || wd_rst_reenable; // RL7 RL8
  wire wd_trip = wd_fail && wd_enable && reset_output_low;

  wire sdm_watch = (mode == `MSC_MODE_INIT) && por_init && vcc_above_rtx && por_flag &&
    reset_output_low; // RL12
  wire crc_window = ((mode == `MSC_MODE_INIT && por_init) || mode == `MSC_MODE_RESTART) &&
    vcc_above_rtx && por_flag && !reset_output_low; // RL17

  // Mode transitions, failures ahead of commands
  always @* begin
    next_mode = mode;
    if (thermal_shutdown && mode != `MSC_MODE_FAILSAFE) begin
      next_mode = `MSC_MODE_FAILSAFE; // RL6
    end else if (mode != `MSC_MODE_FAILSAFE && mode != `MSC_MODE_SLEEP &&
                 mode != `MSC_MODE_RESTART && (regulator_uv || (wd_trip && wd_rst_ok))) begin
      next_mode = `MSC_MODE_RESTART; // RL5
    end else if (soft_cmd && mode != `MSC_MODE_SLEEP && mode != `MSC_MODE_FAILSAFE) begin
      next_mode = `MSC_MODE_INIT; // RL2
    end else begin
      case (mode)
        `MSC_MODE_INIT: begin
          if (mode_cmd && cmd_mode_sel == `MSC_MODE_NORMAL) begin
            next_mode = `MSC_MODE_NORMAL;
          end
        end
        `MSC_MODE_NORMAL: begin
          if (mode_cmd && (cmd_mode_sel == `MSC_MODE_STOP ||
                           cmd_mode_sel == `MSC_MODE_SLEEP)) begin
            next_mode = cmd_mode_sel; // RL1
          end
        end
        `MSC_MODE_STOP: begin
          if (mode_cmd && cmd_mode_sel == `MSC_MODE_NORMAL) begin
            next_mode = `MSC_MODE_NORMAL;
          end
        end
        `MSC_MODE_SLEEP: begin
          if (wake_event) begin
            next_mode = `MSC_MODE_RESTART; // RL5
          end
        end
        `MSC_MODE_RESTART: begin
          if (rd_done) begin
            next_mode = `MSC_MODE_NORMAL;
          end
        end
        `MSC_MODE_FAILSAFE: begin
          // Leaves only once the critical cause is gone
          if (wake_event && !thermal_shutdown) begin
            next_mode = `MSC_MODE_RESTART; // RL5
          end
        end
        default: begin
          next_mode = `MSC_MODE_INIT;
        end
      endcase
    end
  end

  // A change with no mode or reset command behind it is autonomous
  wire auto_change = (next_mode != mode) && !mode_cmd && !soft_cmd;
  wire enter_restart = (next_mode == `MSC_MODE_RESTART) && (mode != `MSC_MODE_RESTART);

  msc_filter #(
    .CYC(TEST_FILT_CYC),
    .INIT(1'h1)
  ) u_test_filt (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .load(rd_done), // RL14
    .run(sdm_watch),
    .pin(int_test_pin_in),
    .filt(test_filt)
  );

  msc_filter #(
    .CYC(CFG_FILT_CYC),
    .INIT(1'h1)
  ) u_crc_filt (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .load(enter_restart),
    .run(crc_window), // RL18
    .pin(pwm_crc_strap_pin),
    .filt(crc_filt)
  );

  always @(posedge clk) begin
    if (sys_rst) begin
      mode <= `MSC_MODE_INIT; // RL22
      por_init <= 1'h1;
      rd_cnt <= 16'h0000;
      reset_output_low <= 1'h0;
      int_test_pullup_en <= 1'h0;
      main_regulator_output <= 1'h1;
      wd_enable <= 1'h0;
      wd_start_long <= 1'h0;
      sdm_active <= `MSC_SDM_RST;
      crc_enable <= `MSC_CRC_RST;
      spi_fail <= 1'h0;
      cmd_accept <= 1'h0;
      wd_fail_int <= 1'h0;
    end else if (clk_en) begin
      mode <= next_mode;
      if (next_mode != `MSC_MODE_INIT) begin
        por_init <= 1'h0;
      end
      if (soft_cmd) begin
        // Soft reset Init is not a power-up Init
        por_init <= 1'h0;
      end

      // Reset output held for the reset delay in Restart and power-up Init
      if (enter_restart) begin
        reset_output_low <= 1'h0; // RL5
        rd_cnt <= 16'h0000;
      end else if (rd_done) begin
        reset_output_low <= 1'h1;
        rd_cnt <= 16'h0000;
      end else if (!reset_output_low && reset_phase) begin
        rd_cnt <= rd_cnt + 16'h0001;
      end

      int_test_pullup_en <= reset_output_low || rd_done; // RL11

      main_regulator_output <= !(next_mode == `MSC_MODE_SLEEP ||
                                 next_mode == `MSC_MODE_FAILSAFE); // RL3 RL4

      wd_enable <= (next_mode == `MSC_MODE_INIT || next_mode == `MSC_MODE_NORMAL ||
                    next_mode == `MSC_MODE_STOP) && (reset_output_low || rd_done);
      wd_start_long <= rd_done; // RL9 RL22

      if (sdm_watch && eff_cmd && !test_filt && !auto_change) begin
        sdm_active <= 1'h1; // RL13
      end else if (sdm_watch && auto_change) begin
        sdm_active <= 1'h0; // RL15
      end

      if (frame_on) begin
        crc_enable <= 1'h1; // RL19
      end else if (frame_off) begin
        crc_enable <= 1'h0; // RL20
      end else if (rd_done && crc_window) begin
        crc_enable <= !crc_filt; // RL16 RL18
      end

      spi_fail <= stop_block; // RL23
      cmd_accept <= eff_cmd; // RL10
      wd_fail_int <= wd_trip && !wd_rst_ok; // RL7
    end
  end
endmodule // msc_top

/* File: test/msc_top_checker.sv */
// Port-level assertions for the mode controller
`timescale 1ns/1ns
`include "msc_consts.vh"
module msc_top_checker (
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire cmd_valid,
  input wire [31:0] cmd_frame,
  input wire cmd_is_write,
  input wire cmd_mode_set,
  input wire [2:0] cmd_mode_sel,
  input wire cmd_soft_reset,
  input wire cmd_wd_refresh,
  input wire cmd_status_access,
  input wire wd_fail,
  input wire regulator_uv,
  input wire thermal_shutdown,
  input wire [2:0] mode,
  input wire reset_output_low,
  input wire main_regulator_output,
  input wire wd_start_long,
  input wire crc_enable,
  input wire spi_fail,
  input wire cmd_accept
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Faults outrank commands, so commands are judged only without them
  wire tk = clk_en && cmd_valid && !wd_fail && !regulator_uv && !thermal_shutdown;
  wire nrm = mode == `MSC_MODE_NORMAL;
  wire ex = (cmd_mode_set && cmd_mode_sel == `MSC_MODE_NORMAL) || cmd_soft_reset
    || cmd_wd_refresh || cmd_status_access;
  sequence s_uv;
    clk_en && regulator_uv && !thermal_shutdown && nrm;
  endsequence
  sequence s_restart;
    mode == `MSC_MODE_RESTART && !reset_output_low;
  endsequence
  stop_vreg_a: assert property (mode == `MSC_MODE_STOP |-> main_regulator_output)
    else $error("regulator off in stop");
  sleep_vreg_a: assert property (mode == `MSC_MODE_SLEEP |-> !main_regulator_output)
    else $error("regulator on in sleep");
  uv_restart_a: assert property (s_uv |=> s_restart)
    else $error("no restart after undervoltage");
  thermal_fs_a: assert property (clk_en && thermal_shutdown |=>
    mode == `MSC_MODE_FAILSAFE) else $error("no fail-safe after overheat");
  stop_refuse_a: assert property (tk && mode == `MSC_MODE_STOP && cmd_is_write && !ex
    |=> spi_fail && !cmd_accept) else $error("stop write not refused");
  crc_on_a: assert property (tk && nrm && cmd_frame == `MSC_FRAME_CRC_ON
    |=> crc_enable) else $error("crc not switched on");
  crc_off_a: assert property (tk && nrm && cmd_frame == `MSC_FRAME_CRC_OFF
    |=> !crc_enable) else $error("crc not switched off");
  release_long_a: assert property ($rose(reset_output_low) |-> wd_start_long)
    else $error("no long window at release");
endmodule // msc_top_checker
bind msc_top msc_top_checker i_msc_top_checker (.clk, .sys_rst, .clk_en, .cmd_valid,
  .cmd_frame, .cmd_is_write, .cmd_mode_set, .cmd_mode_sel, .cmd_soft_reset, .cmd_wd_refresh,
  .cmd_status_access, .wd_fail, .regulator_uv, .thermal_shutdown, .mode, .reset_output_low,
  .main_regulator_output, .wd_start_long, .crc_enable, .spi_fail, .cmd_accept);

/* File: test/msc_host_model.sv */
// Host and board model: frame sender and strap resistors
`timescale 1ns/1ns
module msc_host_model (
  input wire clk,
  input wire sdm_pd,
  input wire crc_pd,
  input wire int_test_pullup_en,
  output logic cmd_valid,
  output logic [31:0] cmd_frame,
  output logic cmd_is_write,
  output logic cmd_mode_set,
  output logic [2:0] cmd_mode_sel,
  output logic cmd_soft_reset,
  output logic cmd_wd_refresh,
  output logic cmd_status_access,
  output wire int_test_pin_in,
  output wire pwm_crc_strap_pin
);
  logic tog = 1'h0;
  // An undriven pin wanders, so an open strap never settles low
  always @(posedge clk) tog <= ~tog;
  assign int_test_pin_in = sdm_pd ? 1'h0 : (int_test_pullup_en ? 1'h1 : tog);
  assign pwm_crc_strap_pin = crc_pd ? 1'h0 : tog;
  initial begin
    cmd_valid = 1'h0;
    {cmd_frame, cmd_is_write, cmd_mode_set, cmd_mode_sel} = '0;
    {cmd_soft_reset, cmd_wd_refresh, cmd_status_access} = '0;
  end
  task send(input logic [31:0] f, input logic [4:0] fl, input logic [2:0] sel);
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd_frame <= f;
    {cmd_is_write, cmd_mode_set, cmd_soft_reset, cmd_wd_refresh, cmd_status_access} <= fl;
    cmd_mode_sel <= sel;
    @(posedge clk);
    cmd_valid <= 1'h0;
    cmd_frame <= ~f;
    #1;
  endtask
endmodule // msc_host_model

/* File: test/msc_top_tb_top.sv */
// Self-checking bench for the mode controller
`timescale 1ns/1ns
`include "msc_consts.vh"
module msc_top_tb_top;
  localparam logic [4:0] W = 5'h10;
  localparam logic [4:0] WM = 5'h18;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [3:0] ev = 4'h0;
  logic pd = 1'h0;
  // Clock enable and watchdog reset re-enable are driven so their logic gets exercised
  logic ce = 1'h1;
  logic wre = 1'h0;
  int n_mismatch = 0;
  int n_checks = 0;
  wire cmd_valid, cmd_is_write, cmd_mode_set, cmd_soft_reset, cmd_wd_refresh;
  wire cmd_status_access, int_test_pin_in, pwm_crc_strap_pin, sdm_active, reset_output_low;
  wire int_test_pullup_en, main_regulator_output, wd_enable, wd_start_long, crc_enable;
  wire spi_fail, cmd_accept, wd_fail_int;
  wire [31:0] cmd_frame;
  wire [2:0] cmd_mode_sel, mode;
  msc_host_model i_msc_host_model (.clk, .sdm_pd(pd), .crc_pd(pd), .int_test_pullup_en,
    .cmd_valid, .cmd_frame, .cmd_is_write, .cmd_mode_set, .cmd_mode_sel, .cmd_soft_reset,
    .cmd_wd_refresh, .cmd_status_access, .int_test_pin_in, .pwm_crc_strap_pin);
  // Short counts keep the run brief
  msc_top #(.RESET_DELAY_CYC(8), .TEST_FILT_CYC(4), .CFG_FILT_CYC(4)) i_msc_top (.clk,
    .sys_rst, .clk_en(ce), .cmd_valid, .cmd_frame, .cmd_is_write, .cmd_mode_set,
    .cmd_mode_sel, .cmd_soft_reset, .cmd_wd_refresh, .cmd_status_access,
    .wd_rst_reenable(wre), .wake_event(ev[3]), .wd_fail(ev[2]), .regulator_uv(ev[1]),
    .thermal_shutdown(ev[0]), .vcc_above_rtx(1'h1), .por_flag(1'h1), .int_test_pin_in,
    .pwm_crc_strap_pin, .mode, .sdm_active, .reset_output_low, .int_test_pullup_en,
    .main_regulator_output, .wd_enable, .wd_start_long, .crc_enable, .spi_fail,
    .cmd_accept, .wd_fail_int);
  initial forever #10 clk = ~clk;
  task ck(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task cm(input logic [2:0] e);
    ck("mode", mode, e);
  endtask
  task tx(input logic [31:0] f, input logic [4:0] fl, input logic [2:0] sel);
    i_msc_host_model.send(f, fl, sel);
  endtask
  task pulse(input logic [3:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 4'h0;
    #1;
  endtask
  task wait_rel;
    for (int i = 0; i < 40 && reset_output_low !== 1'h1; i++) begin
      @(posedge clk);
      #1;
    end
    ck("reset_output_low", reset_output_low, 1'h1);
    ck("long", wd_start_long, 1'h1);
    ck("pullup", int_test_pullup_en, 1'h1);
  endtask
  task rst;
    @(posedge clk);
    sys_rst <= 1'h1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    #1;
    cm(`MSC_MODE_INIT);
    ck("reset_output_low", reset_output_low, 1'h0);
    wait_rel;
    cm(`MSC_MODE_INIT);
    ck("crc", crc_enable, pd);
  endtask
  task give_verdict;
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    rst;
    tx(32'h0, 5'h00, 3'h0);
    @(posedge clk);
    #1;
    ck("sdm", sdm_active, 1'h0);
    tx(32'h0, WM, `MSC_MODE_NORMAL);
    cm(`MSC_MODE_NORMAL);
    tx(`MSC_FRAME_CRC_ON, W, 3'h0);
    ck("crc", crc_enable, 1'h1);
    tx(`MSC_FRAME_CRC_OFF, W, 3'h0);
    ck("crc", crc_enable, 1'h0);
    tx(32'h0, WM, `MSC_MODE_STOP);
    ck("vreg", main_regulator_output, 1'h1);
    tx(32'h12345678, W, 3'h0);
    ck("fail", spi_fail, 1'h1);
    ck("acc", cmd_accept, 1'h0);
    tx(32'h12345678, 5'h12, 3'h0);
    ck("acc", cmd_accept, 1'h1);
    tx(32'h0, WM, `MSC_MODE_NORMAL);
    cm(`MSC_MODE_NORMAL);
    tx(32'h0, WM, `MSC_MODE_SLEEP);
    ck("vreg", main_regulator_output, 1'h0);
    pulse(4'h8);
    cm(`MSC_MODE_RESTART);
    wait_rel;
    cm(`MSC_MODE_NORMAL);
    pulse(4'h2);
    cm(`MSC_MODE_RESTART);
    wait_rel;
    pulse(4'h1);
    cm(`MSC_MODE_FAILSAFE);
    pulse(4'h8);
    wait_rel;
    $display("test modes done");
    pd <= 1'h1;
    rst;
    repeat (6) @(posedge clk);
    tx(32'h0, 5'h00, 3'h0);
    @(posedge clk);
    #1;
    ck("sdm", sdm_active, 1'h1);
    tx(32'h0, WM, `MSC_MODE_NORMAL);
    pulse(4'h4);
    ck("wdint", wd_fail_int, 1'h1);
    cm(`MSC_MODE_NORMAL);
    ck("wden", wd_enable, 1'h1);
    wre <= 1'h1;
    pulse(4'h4);
    cm(`MSC_MODE_RESTART);
    ck("wdint", wd_fail_int, 1'h0);
    wait_rel;
    wre <= 1'h0;
    ce <= 1'h0;
    pulse(4'h2);
    cm(`MSC_MODE_NORMAL);
    ce <= 1'h1;
    @(posedge clk);
    #1;
    cm(`MSC_MODE_NORMAL);
    $display("test dev done");
    give_verdict;
  end
  // Tests need well under 1000 cycles; five thousand means a hang
  initial begin
    #100000;
    n_mismatch++;
    give_verdict;
  end
endmodule // msc_top_tb_top
